/* rtl/fec_erase_ctrl.sv */
/*
 Host-side bulk erase controller for a parallel flash with a command register.
 Assumes the array was already programmed to zero and that the programming supply
 is switched by vppEnable; vppReady reports it is up.
*/
`timescale 1ns/1ps
`include "fec_cfg.svh"
module fec_erase_ctrl #(
   parameter int ERASE_PULSE_CYC = `FEC_ERASE_PULSE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Control
   input wire logic startErase,
   input wire logic preProgrammed,
   input wire logic exitWithProgSetup,
   output logic busy,
   output logic eraseDone,
   output logic eraseFail,
   output logic [9:0] pulseCount,
   output logic [15:0] erase_check_address,
   // Programming supply
   output logic vppEnable,
   input wire logic vppReady,
   // Flash pins
   output logic flashChipSelN,
   output logic flashWriteN,
   output logic flashOutGateN,
   output logic [15:0] flashAddr,
   output logic [7:0] flashDataOut,
   output logic flashDataOe,
   input wire logic [7:0] flashDataIn
);
   localparam int REC = `FEC_VERIFY_REC_CYC;
   logic rstMeta_reg;
   logic rstSync_reg;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   wire rstN = rstSync_reg;

   fec_pkg::fec_state_t state_reg, state_next;
   logic [31:0] timer_reg;
   logic [15:0] addr_reg;
   logic [9:0] pulses_reg;
   logic cycIssued_reg;
   logic done_reg;
   logic fail_reg;
   logic [7:0] checkData;
   logic cycDone;
   fec_pkg::fec_bus_t pins;

   wire inVerify = (state_reg == fec_pkg::FEC_VERIFY);
   wire inRead = (state_reg == fec_pkg::FEC_READ);
   wire inWriteState = (state_reg == fec_pkg::FEC_SETUP) || (state_reg == fec_pkg::FEC_ERASE)
                       || inVerify || (state_reg == fec_pkg::FEC_EXIT);
   wire cycStart = (inWriteState || inRead) && !cycIssued_reg;
   // Command register takes any address except for erase-verify
   wire [15:0] cycAddr = inVerify || inRead ? addr_reg : 16'h0000;
   // FFh leaves the device in read mode until the next command
   wire [7:0] exitCode = exitWithProgSetup ? `FEC_CMD_PROG_SETUP : `FEC_CMD_RESET;
   wire [7:0] cycData = (state_reg == fec_pkg::FEC_EXIT) ? exitCode :
                        inVerify ? `FEC_CMD_ERASE_VERIFY : `FEC_CMD_ERASE;
   wire timerHit = (timer_reg == 32'(ERASE_PULSE_CYC));
   wire recHit = (timer_reg == 32'(REC));
   wire byteOk = (checkData == `FEC_ERASED_BYTE);
   wire lastAddr = (addr_reg == `FEC_ADDR_LAST);
   wire pulseLimit = (pulses_reg == 10'(`FEC_MAX_PULSES));

   fec_write_cycle u_cycle (
      .sysClk(sys_clk),
      .rstN(rstN),
      .start(cycStart),
      .isRead(inRead),
      .addr(cycAddr),
      .data(cycData),
      .done(cycDone),
      .readData(checkData),
      .pins(pins),
      .dataIn(flashDataIn)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         fec_pkg::FEC_IDLE: begin
            // Erase only on a pre-programmed array with supply up
            if (startErase && preProgrammed && vppReady) begin
               state_next = fec_pkg::FEC_SETUP;
            end
         end
         fec_pkg::FEC_SETUP: begin
            if (cycDone) begin
               state_next = fec_pkg::FEC_ERASE;
            end
         end
         fec_pkg::FEC_ERASE: begin
            if (cycDone) begin
               state_next = fec_pkg::FEC_PULSE;
            end
         end
         fec_pkg::FEC_PULSE: begin
            if (timerHit) begin
               state_next = fec_pkg::FEC_VERIFY;
            end
         end
         fec_pkg::FEC_VERIFY: begin
            if (cycDone) begin
               state_next = fec_pkg::FEC_RECOVER;
            end
         end
         fec_pkg::FEC_RECOVER: begin
            if (recHit) begin
               state_next = fec_pkg::FEC_READ;
            end
         end
         fec_pkg::FEC_READ: begin
            if (cycDone) begin
               state_next = fec_pkg::FEC_CHECK;
            end
         end
         fec_pkg::FEC_CHECK: begin
            if (byteOk && lastAddr) begin
               state_next = fec_pkg::FEC_EXIT;
            end else if (byteOk) begin
               state_next = fec_pkg::FEC_VERIFY;
            end else if (pulseLimit) begin
               state_next = fec_pkg::FEC_EXIT;
            end else begin
               state_next = fec_pkg::FEC_SETUP;
            end
         end
         fec_pkg::FEC_EXIT: begin
            if (cycDone) begin
               state_next = fec_pkg::FEC_DONE;
            end
         end
         fec_pkg::FEC_DONE: begin
            state_next = fec_pkg::FEC_IDLE;
         end
         default: begin
            state_next = fec_pkg::FEC_IDLE;
         end
      endcase
      // Supply lost mid-sequence: device falls back to read mode, so abandon
      if (!vppReady && state_reg != fec_pkg::FEC_IDLE) begin
         state_next = fec_pkg::FEC_IDLE;
      end
   end

   wire enterCheck = (state_reg == fec_pkg::FEC_CHECK);
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= fec_pkg::FEC_IDLE;
         timer_reg <= 32'h0000_0000;
         addr_reg <= 16'h0000;
         pulses_reg <= 10'h000;
         cycIssued_reg <= 1'b0;
         done_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // Timer restarts on every state change
         timer_reg <= (state_next != state_reg) ? 32'h0000_0000 : timer_reg + 32'h0000_0001;
         cycIssued_reg <= (state_next != state_reg) ? 1'b0 : (cycIssued_reg | cycStart);
         if (state_reg == fec_pkg::FEC_IDLE && state_next == fec_pkg::FEC_SETUP) begin
            addr_reg <= 16'h0000;
            pulses_reg <= 10'h000;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
         end
         if (state_reg == fec_pkg::FEC_ERASE && cycDone) begin
            pulses_reg <= pulses_reg + 10'h001;
         end
         // Failing address is kept so the next pass resumes there
         if (enterCheck && byteOk && !lastAddr) begin
            addr_reg <= addr_reg + 16'h0001;
         end
         if (state_reg == fec_pkg::FEC_EXIT && cycDone) begin
            done_reg <= byteOk;
            fail_reg <= !byteOk;
         end
      end
   end

   // Supply stays on through erase and verify; dropped only when idle
   assign vppEnable = (state_reg != fec_pkg::FEC_IDLE) || startErase;
   assign busy = (state_reg != fec_pkg::FEC_IDLE);
   assign eraseDone = done_reg;
   assign eraseFail = fail_reg;
   assign pulseCount = pulses_reg;
   assign erase_check_address = addr_reg;
   assign flashChipSelN = pins.chipSelN;
   assign flashWriteN = pins.writeN;
   assign flashOutGateN = pins.outGateN;
   assign flashAddr = pins.addr;
   assign flashDataOut = pins.dataOut;
   assign flashDataOe = pins.dataOe;
endmodule : fec_erase_ctrl

/* rtl/fec_cfg.svh */
/*
 Constants for the flash erase controller: command codes, pin timing counts, array limits.
 Assumes a 40 MHz system clock.
*/
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH
`define FEC_CLK_MHZ 40
`define FEC_CMD_READ 8'h00
`define FEC_CMD_ERASE 8'h20
`define FEC_CMD_PROG_SETUP 8'h40
`define FEC_CMD_ERASE_VERIFY 8'hA0
`define FEC_CMD_RESET 8'hFF
`define FEC_ZERO_BYTE 8'h00
`define FEC_ERASED_BYTE 8'hFF
`define FEC_ADDR_LAST 16'hFFFF
`define FEC_WE_LOW_NS 100
`define FEC_WE_LOW_CYC ((`FEC_WE_LOW_NS * `FEC_CLK_MHZ + 999) / 1000)
`define FEC_READ_NS 200
`define FEC_READ_CYC ((`FEC_READ_NS * `FEC_CLK_MHZ + 999) / 1000)
`define FEC_VERIFY_REC_US 6
`define FEC_VERIFY_REC_CYC ((`FEC_VERIFY_REC_US * `FEC_CLK_MHZ))
`define FEC_ERASE_PULSE_MS 10
`define FEC_ERASE_PULSE_CYC (`FEC_ERASE_PULSE_MS * 1000 * `FEC_CLK_MHZ)
`define FEC_MAX_PULSES 1000
`endif

/* rtl/fec_pkg.sv */
/*
 Types for the flash erase controller.
 Assumes fec_cfg.svh supplies all numeric constants.
*/
package fec_pkg;
   typedef enum logic [3:0] {
      FEC_IDLE = 4'b0000,
      FEC_SETUP = 4'b0001,
      FEC_ERASE = 4'b0010,
      FEC_PULSE = 4'b0011,
      FEC_VERIFY = 4'b0100,
      FEC_RECOVER = 4'b0101,
      FEC_READ = 4'b0110,
      FEC_CHECK = 4'b0111,
      FEC_EXIT = 4'b1000,
      FEC_DONE = 4'b1001,
      FEC_FAIL = 4'b1010
   } fec_state_t;
   typedef struct packed {
      logic chipSelN;
      logic writeN;
      logic outGateN;
      logic [15:0] addr;
      logic [7:0] dataOut;
      logic dataOe;
   } fec_bus_t;
endpackage : fec_pkg

/* rtl/fec_write_cycle.sv */
/*
 One flash bus cycle: write (strobe low then high) or read (gate low, sample data).
 Assumes the flash pins are driven directly and inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "fec_cfg.svh"
module fec_write_cycle (
   // Clock and reset
   input wire logic sysClk,
   input wire logic rstN,
   // Request
   input wire logic start,
   input wire logic isRead,
   input wire logic [15:0] addr,
   input wire logic [7:0] data,
   output logic done,
   output logic [7:0] readData,
   // Flash pins
   output fec_pkg::fec_bus_t pins,
   input wire logic [7:0] dataIn
);
   localparam int WLOW = `FEC_WE_LOW_CYC;
   localparam int RLOW = `FEC_READ_CYC;
   logic [7:0] cnt_reg;
   logic busy_reg;
   logic rd_reg;
   wire lastCnt = rd_reg ? (cnt_reg == 8'(RLOW)) : (cnt_reg == 8'(WLOW));
   wire finish = busy_reg && lastCnt;
   assign done = finish;
   always_ff @(posedge sysClk or negedge rstN) begin
      if (!rstN) begin
         cnt_reg <= 8'h00;
         busy_reg <= 1'b0;
         rd_reg <= 1'b0;
         readData <= 8'h00;
         pins <= '{chipSelN: 1'b1, writeN: 1'b1, outGateN: 1'b1, addr: 16'h0000,
                   dataOut: 8'h00, dataOe: 1'b0};
      end else if (start && !busy_reg) begin
         // Address and data driven with the strobe fall, held until it rises
         busy_reg <= 1'b1;
         rd_reg <= isRead;
         cnt_reg <= 8'h01;
         pins.addr <= addr;
         pins.dataOut <= data;
         pins.dataOe <= !isRead;
         pins.chipSelN <= 1'b0;
         pins.writeN <= isRead;
         // Output gate stays high through a write
         pins.outGateN <= !isRead;
      end else if (finish) begin
         busy_reg <= 1'b0;
         if (rd_reg) begin
            readData <= dataIn;
         end
         pins.chipSelN <= 1'b1;
         pins.writeN <= 1'b1;
         pins.outGateN <= 1'b1;
         pins.dataOe <= 1'b0;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : fec_write_cycle

/* test/fec_erase_ctrl_asserts.sv */
/*
 Pin-level checker for the flash erase controller.
 Assumes it is bound into fec_erase_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module fec_erase_ctrl_asserts #(
   parameter int ERASE_PULSE_CYC = 50
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Control
   input wire logic startErase,
   input wire logic preProgrammed,
   input wire logic busy,
   // Supply
   input wire logic vppEnable,
   input wire logic vppReady,
   // Flash pins
   input wire logic flashChipSelN,
   input wire logic flashWriteN,
   input wire logic flashOutGateN,
   input wire logic [15:0] flashAddr,
   input wire logic [7:0] flashDataOut,
   input wire logic flashDataOe
);
   // Cycles since the last strobe low and since the last verify write
   int gap_reg;
   int rec_reg;
   logic [7:0] last_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_reg <= 0;
         rec_reg <= 0;
         last_reg <= 8'h00;
      end else begin
         gap_reg <= !flashWriteN ? 0 : gap_reg + 1;
         rec_reg <= (!flashWriteN && flashDataOut == 8'hA0) ? 0 : rec_reg + 1;
         last_reg <= !flashWriteN ? flashDataOut : last_reg;
      end
   end
   property p_wgate; !flashWriteN |-> flashOutGateN && !flashChipSelN && flashDataOe; endproperty
   a_wgate: assert property (p_wgate) else $error("write with bad pin state");
   property p_wlen; $fell(flashWriteN) |-> !flashWriteN [*4] ##1 flashWriteN; endproperty
   a_wlen: assert property (p_wlen) else $error("strobe low time wrong");
   property p_whold;
      !flashWriteN && !$fell(flashWriteN) |-> $stable(flashAddr) && $stable(flashDataOut);
   endproperty
   a_whold: assert property (p_whold) else $error("address or data moved");
   property p_supply; $fell(flashWriteN) |-> vppEnable && vppReady; endproperty
   a_supply: assert property (p_supply) else $error("command without supply");
   property p_rsafe; !flashOutGateN |-> flashWriteN && !flashDataOe; endproperty
   a_rsafe: assert property (p_rsafe) else $error("read while driving");
   property p_recover; $fell(flashOutGateN) |-> rec_reg >= 240; endproperty
   a_recover: assert property (p_recover) else $error("verify read too early");
   property p_pulse;
      $fell(flashWriteN) && flashDataOut == 8'hA0 && last_reg == 8'h20
         |-> gap_reg >= ERASE_PULSE_CYC && gap_reg <= ERASE_PULSE_CYC + 20;
   endproperty
   a_pulse: assert property (p_pulse) else $error("erase pulse length wrong");
   property p_refuse; !busy && startErase && !(preProgrammed && vppReady) |=> !busy; endproperty
   a_refuse: assert property (p_refuse) else $error("start not refused");
   property p_abort; busy && !vppReady |-> ##[1:20] !busy; endproperty
   a_abort: assert property (p_abort) else $error("no abort on supply loss");
   property p_busyvpp; busy |-> vppEnable; endproperty
   a_busyvpp: assert property (p_busyvpp) else $error("supply off while busy");
   property p_wbusy; $fell(flashWriteN) |-> busy; endproperty
   a_wbusy: assert property (p_wbusy) else $error("strobe outside a sequence");
   property p_codes;
      !flashWriteN |-> flashDataOut inside {8'h20, 8'hA0, 8'h40, 8'hFF};
   endproperty
   a_codes: assert property (p_codes) else $error("undefined command code");
endmodule : fec_erase_ctrl_asserts
bind fec_erase_ctrl fec_erase_ctrl_asserts #(.ERASE_PULSE_CYC(ERASE_PULSE_CYC)) i_chk (
   .sys_clk, .arst_n, .startErase, .preProgrammed, .busy, .vppEnable, .vppReady,
   .flashChipSelN, .flashWriteN, .flashOutGateN, .flashAddr, .flashDataOut, .flashDataOe);

/* test/fec_flash_model.sv */
/*
 Behavioural flash device: command register, bulk erase, margin verify.
 Assumes host pins of fec_erase_ctrl; one byte fails until the second pulse.
*/
`timescale 1ns/1ps
module fec_flash_model #(
   parameter logic [15:0] FAIL_ADDR = 16'h0002
) (
   // Supply and control pins
   input wire logic vppOn,
   input wire logic csN,
   input wire logic weN,
   input wire logic oeN,
   // Address and data
   input wire logic [15:0] addr,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   logic [7:0] cmd = 8'h00;
   logic [15:0] adrLat = 16'h0000;
   logic armed = 1'b0;
   logic erasing = 1'b0;
   int pulses = 0;
   logic [7:0] logD[$];
   logic [15:0] logA[$];
   logic [7:0] rd;
   logic wrOk = 1'b0;
   // Later of select or strobe fall latches the address
   // Host moves select, strobe and address in one step, so look once they settle
   always @(negedge weN or negedge csN) begin
      #1;
      if (!weN && !csN) begin
         adrLat = addr;
         wrOk = oeN;
      end
   end
   // Inactive without supply, read code again on power-up
   always @(posedge weN or negedge vppOn) begin
      if (!vppOn) begin
         cmd = 8'h00;
         armed = 1'b0;
         erasing = 1'b0;
      end else if (wrOk) begin
         // Select may rise with the strobe, so its state is taken at the fall
         wrOk = 1'b0;
         logD.push_back(din);
         logA.push_back(adrLat);
         if (din == 8'hA0) erasing = 1'b0;
         if (din == 8'h20 && armed) begin
            erasing = 1'b1;
            pulses++;
         end
         armed = din == 8'h20 && !armed;
         // Unknown codes keep the mode
         if (din inside {8'h00, 8'h20, 8'h40, 8'hA0, 8'hFF}) cmd = (din == 8'hFF) ? 8'h00 : din;
      end
   end
   // Margin read fails the weak byte until two pulses
   assign rd = (cmd == 8'hA0 && adrLat == FAIL_ADDR && pulses < 2) ? 8'h00 : 8'hFF;
   // Released bus shows the inverse so a stale sample cannot pass
   assign dout = (!csN && !oeN) ? rd : ~rd;
endmodule : fec_flash_model

/* test/tb_top.sv */
/*
 Testbench for the flash erase controller.
 Assumes fec_flash_model at the pins and a pulse shortened to 50 cycles.
*/
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic startErase = 1'b0;
   logic preProgrammed = 1'b0;
   logic exitWithProgSetup = 1'b0;
   logic vppReady = 1'b0;
   logic busy, eraseDone, eraseFail, vppEnable;
   logic [9:0] pulseCount;
   logic [15:0] chkAddr, flashAddr;
   logic flashChipSelN, flashWriteN, flashOutGateN, flashDataOe;
   logic [7:0] flashDataOut, flashDataIn;
   int mismatches = 0;
   int tests_run = 0;
   always #12.5 sys_clk = ~sys_clk;
   fec_erase_ctrl #(.ERASE_PULSE_CYC(50)) i_fec_erase_ctrl (
      .sys_clk, .arst_n, .startErase, .preProgrammed, .exitWithProgSetup, .busy, .eraseDone,
      .eraseFail, .pulseCount, .erase_check_address(chkAddr), .vppEnable, .vppReady,
      .flashChipSelN, .flashWriteN, .flashOutGateN, .flashAddr, .flashDataOut,
      .flashDataOe, .flashDataIn);
   fec_flash_model i_fec_flash_model (.vppOn(vppEnable && vppReady), .csN(flashChipSelN),
      .weN(flashWriteN), .oeN(flashOutGateN), .addr(flashAddr), .din(flashDataOut),
      .dout(flashDataIn));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic t_refuse;
      vppReady = 1'b1;
      startErase = 1'b1;
      tick(10);
      check("busy no preprog", 16'(busy), 16'h0);
      preProgrammed = 1'b1;
      vppReady = 1'b0;
      tick(10);
      check("busy no supply", 16'(busy), 16'h0);
      check("writes", 16'(i_fec_flash_model.logD.size()), 16'h0);
      startErase = 1'b0;
   endtask : t_refuse
   task automatic t_erase;
      logic [7:0] expD[9] = '{8'h20, 8'h20, 8'hA0, 8'hA0, 8'hA0, 8'h20, 8'h20, 8'hA0, 8'hA0};
      logic [15:0] expA[9] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h0, 16'h0, 16'h2, 16'h3};
      int n = 0;
      vppReady = 1'b1;
      startErase = 1'b1;
      tick(2);
      check("busy", 16'(busy), 16'h1);
      startErase = 1'b0;
      while (i_fec_flash_model.logD.size() < 9 && n < 5000) begin
         tick(1);
         n++;
      end
      for (int i = 0; i < 9; i++) begin
         check("cmd", 16'(i_fec_flash_model.logD[i]), 16'(expD[i]));
         if (expD[i] == 8'hA0) check("addr", i_fec_flash_model.logA[i], expA[i]);
      end
      check("pulses", 16'(pulseCount), 16'h2);
      check("verify addr", chkAddr, 16'h3);
      check("done", 16'({eraseDone, eraseFail}), 16'h0);
   endtask : t_erase
   task automatic t_abort;
      int n = 0;
      vppReady = 1'b0;
      while (busy === 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      check("busy abort", 16'(busy), 16'h0);
      check("flags", 16'({eraseDone, eraseFail}), 16'h0);
      check("pins idle", 16'({flashChipSelN, flashWriteN, flashOutGateN, flashDataOe}),
         16'hE);
   endtask : t_abort
   initial begin
      tick(4);
      arst_n = 1'b1;
      tick(4);
      t_refuse();
      t_erase();
      t_abort();
      end_of_test();
   end
   // Whole run needs about 1200 cycles; over sixteen times that means a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
endmodule : tb_top
